// >>> bench/srai_host_model.sv
// Behavioural SPI host that frames command and data transfers for the serial port.
module srai_host_model (
	output logic      sclk,
	output logic      cs_n,
	output logic      din,
	input  wire logic dout,
	input  wire logic dout_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	logic last_q;
	// A released data line must not keep showing the last bit, so it reads inverted.
	wire  miso = dout_oe ? dout : ~last_q;
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din = 1'b0;
		last_q = 1'b0;
	end
	task automatic shift(input logic b, output logic r);
		sclk = 1'b1;
		din = b;
		#62.5;
		r = miso;
		last_q = miso;
		sclk = 1'b0;
		#62.5;
	endtask
	task automatic frame(input logic wr, input logic [5:0] a, input int n, input int nsend,
		input logic [23:0] wdata, output logic [23:0] rdata);
		logic [7:0] cmd;
		logic       r;
		cmd = {wr, 1'b0, a};
		rdata = '0;
		cs_n = 1'b0;
		#100;
		for (int i = 7; i >= 0; i--) begin
			shift(cmd[i], r);
		end
		for (int i = n - 1; i >= n - nsend; i--) begin
			shift(wdata[i], r);
			rdata[i] = r;
		end
		#100;
		cs_n = 1'b1;
		din = ~din;
		#1000;
	endtask
endmodule

// >>> bench/srai_serial_port_test.sv
// Self-checking bench of the serial register port against a behavioural register model.
module srai_serial_port_test import srai_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic        core_clk, rst_n, sclk, cs_n, din, dout, dout_oe, irq_out, irq_oe, half_cycle;
	srai_power_t power;
	logic [15:0] irq_events, m_en, m_flags, e;
	logic [7:0]  m_acfg, m_vcfg;
	logic [23:0] m_act, m_app, m_line, rd;
	int          fails, num_checks, cycles;

	srai_serial_port DUT (.core_clk(core_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
		.din(din), .dout(dout), .dout_oe(dout_oe), .irq_out(irq_out), .irq_oe(irq_oe),
		.power(power), .half_cycle(half_cycle), .irq_events(irq_events));
	srai_host_model host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			fails++;
			wrap_up();
		end
	end
	task automatic check(input string nm, input logic [23:0] x, input logic [23:0] g);
		num_checks++;
		if (g !== x) begin
			$display("unexpected %s: expected %h, seen %h", nm, x, g);
			fails++;
		end
	endtask
	task automatic rd_reg(input logic [5:0] a, input int n, input logic [23:0] x);
		host.frame(1'b0, a, n, n, 24'h0, rd);
		check($sformatf("register %h", a), x, rd);
	endtask
	task automatic wr_reg(input logic [5:0] a, input int n, input logic [23:0] d);
		host.frame(1'b1, a, n, n, d, rd);
	endtask
	task automatic irq_is(input logic x);
		repeat (3) @(posedge core_clk);
		#1;
		check("irq_oe", {23'h0, x}, {23'h0, irq_oe});
		check("irq_out", 24'h0, {23'h0, irq_out});
		check("dout_oe", 24'h0, {23'h0, dout_oe});
	endtask
	task automatic pulse_evt(input logic [15:0] b);
		m_flags |= b;
		@(posedge core_clk);
		irq_events <= b;
		@(posedge core_clk);
		irq_events <= '0;
	endtask
	task automatic pulse_pwr();
		srai_power_t p;
		p.valid = 1'b1;
		for (int i = 0; i < 3; i++) begin
			p.act[i] = 16'($urandom);
			p.app[i] = 16'($urandom);
			if (m_acfg[3 + i]) m_act += 24'(p.act[i]);
			if (m_vcfg[3 + i]) m_app += 24'(p.app[i]);
			if (m_acfg[i]) m_line += 24'(p.act[i]);
		end
		@(posedge core_clk);
		power <= p;
		@(posedge core_clk);
		power.valid <= 1'b0;
	endtask
	task automatic pulse_half();
		@(posedge core_clk);
		half_cycle <= 1'b1;
		@(posedge core_clk);
		half_cycle <= 1'b0;
	endtask

	initial begin
		rst_n = 1'b0;
		power = '0;
		half_cycle = 1'b0;
		irq_events = '0;
		{m_flags, m_act, m_app, m_line, fails, num_checks, cycles} = '0;
		void'($urandom(32'h2498));
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		rd_reg(6'h0d, 8, 24'h3f);
		rd_reg(6'h0e, 8, 24'h3f);
		rd_reg(6'h0f, 16, 24'h0);
		rd_reg(6'h13, 16, 24'h0100);
		rd_reg(6'h00, 8, 24'h0);
		rd_reg(6'h3f, 8, 24'h0);
		irq_is(1'b0);
		m_acfg = 8'($urandom);
		m_vcfg = 8'($urandom);
		wr_reg(6'h0d, 8, {16'h0, m_acfg});
		wr_reg(6'h0e, 8, {16'h0, m_vcfg});
		// A write cut short by chip select must leave the register untouched.
		host.frame(1'b1, 6'h0e, 8, 5, {16'h0, ~m_vcfg}, rd);
		rd_reg(6'h0d, 8, {16'h0, m_acfg});
		rd_reg(6'h0e, 8, {16'h0, m_vcfg});
		wr_reg(6'h01, 24, 24'h5a5a5a);
		wr_reg(6'h13, 16, 24'h000002);
		rd_reg(6'h13, 16, 24'h000002);
		repeat (6) pulse_pwr();
		pulse_half();
		rd_reg(6'h03, 24, 24'h0);
		pulse_half();
		rd_reg(6'h03, 24, m_line);
		rd_reg(6'h01, 24, m_act);
		rd_reg(6'h04, 24, m_app);
		rd_reg(6'h02, 24, m_act);
		m_act = '0;
		rd_reg(6'h01, 24, m_act);
		m_en = (16'($urandom) & 16'hfffc) | 16'h0002;
		wr_reg(6'h0f, 16, {8'h0, m_en});
		rd_reg(6'h0f, 16, {8'h0, m_en});
		pulse_evt(16'h0001);
		irq_is(1'b0);
		rd_reg(6'h10, 16, {8'h0, m_flags});
		pulse_evt(16'h0002);
		irq_is(1'b1);
		// The service routine reads with reset; a new event arrives mid-transfer.
		e = m_flags;
		m_flags = '0;
		fork
			host.frame(1'b0, 6'h11, 16, 16, 24'h0, rd);
			begin
				#1600;
				check("irq_oe mid read", 24'h0, {23'h0, irq_oe});
				pulse_evt(16'h0002);
				#1300;
				check("irq_oe late read", 24'h0, {23'h0, irq_oe});
			end
		join
		check("status with reset", {8'h0, e}, rd);
		irq_is(1'b1);
		rd_reg(6'h11, 16, {8'h0, m_flags});
		m_flags = '0;
		irq_is(1'b0);
		rd_reg(6'h10, 16, 24'h0);
		wrap_up();
	end
endmodule

// >>> design/srai_defines.svh
// Register offsets, field positions and reset values of the serial register port.
`ifndef SRAI_DEFINES_SVH
`define SRAI_DEFINES_SVH

`define SRAI_A_RESERVED   6'h00
`define SRAI_A_ACT_TOTAL  6'h01
`define SRAI_A_ACT_RCLR   6'h02
`define SRAI_A_LINE_ACT   6'h03
`define SRAI_A_APP_TOTAL  6'h04
`define SRAI_A_ACT_CFG    6'h0d
`define SRAI_A_APP_CFG    6'h0e
`define SRAI_A_IRQ_EN     6'h0f
`define SRAI_A_FLAGS      6'h10
`define SRAI_A_FLAGS_RCLR 6'h11
`define SRAI_A_HALF_CYC   6'h13

`define SRAI_CMD_WR_BIT   7
`define SRAI_SEL_LSB      0
`define SRAI_SEL_W        6
`define SRAI_TOT_SEL_LSB  3
`define SRAI_LINE_SEL_LSB 0
`define SRAI_PHASE_SEL_W  3

`define SRAI_W_ENERGY     5'd24
`define SRAI_W_WORD       5'd16
`define SRAI_W_BYTE       5'd8
`define SRAI_CMD_LAST     5'd7

`define SRAI_RST_ACT_CFG  8'h3f
`define SRAI_RST_APP_CFG  8'h3f
`define SRAI_RST_IRQ_EN   16'h0000
`define SRAI_RST_HALF_CYC 16'h0100

`endif

// >>> design/srai_pin_sync.sv
// Two-flop synchroniser for the serial pins with serial clock edge detection.
module srai_pin_sync
	import srai_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire srai_pins_t pins_in,
	output srai_pins_t      pins,
	output logic            sclk_rise,
	output logic            sclk_fall
);

	// The serial clock idles low, so leaving reset shows no false edge on it.
	localparam srai_pins_t PINS_IDLE = '{sclk: 1'b0, cs_n: 1'b1, din: 1'b0};

	srai_sync_t s_r;
	srai_sync_t s_nxt;

	always_comb begin
		s_nxt        = s_r;
		s_nxt.s1     = pins_in;
		s_nxt.s2     = s_r.s1;
		s_nxt.sclk_d = s_r.s2.sclk;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '{s1: PINS_IDLE, s2: PINS_IDLE, sclk_d: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	// Edges are taken from the second stage only; the first stage may be metastable.
	assign pins      = s_r.s2;
	assign sclk_rise = s_r.s2.sclk & ~s_r.sclk_d;
	assign sclk_fall = ~s_r.s2.sclk & s_r.sclk_d;

endmodule

// >>> design/srai_pkg.sv
// Types shared by the serial register port and its pin synchroniser.
package srai_pkg;

	typedef enum logic {
		SRAI_CMD,
		SRAI_DATA
	} srai_state_t;

	typedef struct packed {
		logic sclk;
		logic cs_n;
		logic din;
	} srai_pins_t;

	typedef struct packed {
		logic             valid;
		logic [2:0][15:0] act;
		logic [2:0][15:0] app;
	} srai_power_t;

	typedef struct packed {
		srai_pins_t s1;
		srai_pins_t s2;
		logic       sclk_d;
	} srai_sync_t;

	typedef struct packed {
		srai_state_t st;
		logic [4:0]  bitcnt;
		logic [4:0]  nbits;
		logic [7:0]  cmd;
		logic [23:0] shreg;
		logic [23:0] dout_sh;
		logic        dout;
		logic        dout_oe;
		logic        irq_out;
		logic        irq_oe;
		logic        irq_hold;
		logic [23:0] act_acc;
		logic [23:0] line_acc;
		logic [23:0] line_reg;
		logic [23:0] app_acc;
		logic [15:0] half_cnt;
		logic [7:0]  act_cfg;
		logic [7:0]  app_cfg;
		logic [15:0] irq_en;
		logic [15:0] flags;
		logic [15:0] half_cyc;
	} srai_state_r_t;

endpackage

// >>> design/srai_serial_port.sv
// Serial register port of the energy meter with its open-drain interrupt request line.
`include "srai_defines.svh"

module srai_serial_port
	import srai_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        sclk,
	input  wire logic        cs_n,
	input  wire logic        din,
	output logic             dout,
	output logic             dout_oe,
	output logic             irq_out,
	output logic             irq_oe,
	input  wire srai_power_t power,
	input  wire logic        half_cycle,
	input  wire logic [15:0] irq_events
);

	srai_state_r_t s_r;
	srai_state_r_t s_nxt;
	srai_pins_t    pins;
	logic          sclk_rise;
	logic          sclk_fall;
	logic          cmd_done;
	logic          data_done;
	logic [7:0]    cmd_byte;
	logic [23:0]   wdata;
	logic [23:0]   rdata;
	logic [23:0]   act_inc;
	logic [23:0]   app_inc;
	logic [23:0]   line_inc;
	srai_pins_t    pins_raw;
	logic [5:0]    cmd_sel;
	logic [5:0]    data_sel;

	// Transfer length of each register; unmapped addresses use one byte.
	function automatic logic [4:0] reg_bits(input logic [5:0] a);
		case (a)
			`SRAI_A_ACT_TOTAL, `SRAI_A_ACT_RCLR, `SRAI_A_LINE_ACT, `SRAI_A_APP_TOTAL: begin
				reg_bits = `SRAI_W_ENERGY;
			end
			`SRAI_A_IRQ_EN, `SRAI_A_FLAGS, `SRAI_A_FLAGS_RCLR, `SRAI_A_HALF_CYC: begin
				reg_bits = `SRAI_W_WORD;
			end
			default: begin
				reg_bits = `SRAI_W_BYTE;
			end
		endcase
	endfunction

	// Each set bit of the selection adds the matching phase into the energy sum.
	function automatic logic [23:0] phase_sum(input logic [2:0][15:0] v, input logic [2:0] sel);
		phase_sum = 24'h000000;
		for (int i = 0; i < 3; i++) begin
			if (sel[i]) begin
				phase_sum = phase_sum + {8'h00, v[i]};
			end
		end
	endfunction

	// The three pins travel together so that data and clock see the same two-flop delay.
	assign pins_raw = '{sclk: sclk, cs_n: cs_n, din: din};

	srai_pin_sync u_sync (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.pins_in   (pins_raw),
		.pins      (pins),
		.sclk_rise (sclk_rise),
		.sclk_fall (sclk_fall)
	);

	assign cmd_byte = {s_r.shreg[6:0], pins.din};
	assign wdata    = {s_r.shreg[22:0], pins.din};
	assign cmd_sel  = cmd_byte[`SRAI_SEL_LSB +: `SRAI_SEL_W];
	assign data_sel = s_r.cmd[`SRAI_SEL_LSB +: `SRAI_SEL_W];
	assign act_inc  = phase_sum(power.act, s_r.act_cfg[`SRAI_TOT_SEL_LSB +: `SRAI_PHASE_SEL_W]);
	assign app_inc  = phase_sum(power.app, s_r.app_cfg[`SRAI_TOT_SEL_LSB +: `SRAI_PHASE_SEL_W]);
	assign line_inc = phase_sum(power.act, s_r.act_cfg[`SRAI_LINE_SEL_LSB +: `SRAI_PHASE_SEL_W]);
	assign cmd_done = sclk_fall && !pins.cs_n && s_r.st == SRAI_CMD
		&& s_r.bitcnt == `SRAI_CMD_LAST;
	assign data_done = sclk_fall && !pins.cs_n && s_r.st == SRAI_DATA
		&& s_r.bitcnt == s_r.nbits - 5'd1;

	// The whole register is captured at command time so a multibyte read is coherent.
	always_comb begin
		case (cmd_sel)
			`SRAI_A_ACT_TOTAL:  rdata = s_r.act_acc;
			`SRAI_A_ACT_RCLR:   rdata = s_r.act_acc;
			`SRAI_A_LINE_ACT:   rdata = s_r.line_reg;
			`SRAI_A_APP_TOTAL:  rdata = s_r.app_acc;
			`SRAI_A_ACT_CFG:    rdata = {16'h0000, s_r.act_cfg};
			`SRAI_A_APP_CFG:    rdata = {16'h0000, s_r.app_cfg};
			`SRAI_A_IRQ_EN:     rdata = {8'h00, s_r.irq_en};
			`SRAI_A_FLAGS:      rdata = {8'h00, s_r.flags};
			`SRAI_A_FLAGS_RCLR: rdata = {8'h00, s_r.flags};
			`SRAI_A_HALF_CYC:   rdata = {8'h00, s_r.half_cyc};
			default:            rdata = 24'h000000;
		endcase
	end

	always_comb begin
		s_nxt = s_r;

		// The accumulators wrap at 24 bits; the host must read them often enough.
		if (power.valid) begin
			s_nxt.act_acc  = s_r.act_acc + act_inc;
			s_nxt.line_acc = s_r.line_acc + line_inc;
			s_nxt.app_acc  = s_r.app_acc + app_inc;
		end

		// The line register is refreshed once per programmed number of half cycles.
		if (half_cycle) begin
			if (s_r.half_cnt + 16'h0001 >= s_r.half_cyc) begin
				s_nxt.line_reg = s_nxt.line_acc;
				s_nxt.line_acc = 24'h000000;
				s_nxt.half_cnt = 16'h0000;
			end else begin
				s_nxt.half_cnt = s_r.half_cnt + 16'h0001;
			end
		end

		s_nxt.flags = s_r.flags | irq_events;

		if (pins.cs_n) begin
			s_nxt.st       = SRAI_CMD;
			s_nxt.bitcnt   = 5'd0;
			s_nxt.dout_oe  = 1'b0;
			s_nxt.irq_hold = 1'b0;
		end else begin
			if (sclk_rise && s_r.st == SRAI_DATA && !s_r.cmd[`SRAI_CMD_WR_BIT]) begin
				s_nxt.dout    = s_r.dout_sh[23];
				s_nxt.dout_sh = {s_r.dout_sh[22:0], 1'b0};
				s_nxt.dout_oe = 1'b1;
			end
			if (sclk_fall) begin
				s_nxt.shreg  = wdata;
				s_nxt.bitcnt = s_r.bitcnt + 5'd1;
			end
			if (cmd_done) begin
				s_nxt.cmd    = cmd_byte;
				s_nxt.nbits  = reg_bits(cmd_sel);
				s_nxt.st     = SRAI_DATA;
				s_nxt.bitcnt = 5'd0;
				if (!cmd_byte[`SRAI_CMD_WR_BIT]) begin
					s_nxt.dout_sh = rdata << (`SRAI_W_ENERGY - reg_bits(cmd_sel));
					// A sample landing in the clearing cycle starts the new total.
					if (cmd_sel == `SRAI_A_ACT_RCLR) begin
						s_nxt.act_acc = power.valid ? act_inc : 24'h000000;
					end
					// Events of the clearing cycle survive the clear.
					if (cmd_sel == `SRAI_A_FLAGS_RCLR) begin
						s_nxt.flags    = irq_events;
						s_nxt.irq_hold = 1'b1;
					end
				end
			end else if (data_done) begin
				s_nxt.st       = SRAI_CMD;
				s_nxt.bitcnt   = 5'd0;
				s_nxt.dout_oe  = 1'b0;
				s_nxt.irq_hold = 1'b0;
				if (s_r.cmd[`SRAI_CMD_WR_BIT]) begin
					case (data_sel)
						`SRAI_A_ACT_CFG:  s_nxt.act_cfg  = wdata[7:0];
						`SRAI_A_APP_CFG:  s_nxt.app_cfg  = wdata[7:0];
						`SRAI_A_IRQ_EN:   s_nxt.irq_en   = wdata[15:0];
						`SRAI_A_HALF_CYC: s_nxt.half_cyc = wdata[15:0];
						default:          s_nxt.half_cyc = s_r.half_cyc;
					endcase
				end
			end
		end

		s_nxt.irq_out = 1'b0;
		s_nxt.irq_oe  = !s_nxt.irq_hold && |(s_nxt.flags & s_nxt.irq_en);
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r          <= '0;
			s_r.st       <= SRAI_CMD;
			s_r.act_cfg  <= `SRAI_RST_ACT_CFG;
			s_r.app_cfg  <= `SRAI_RST_APP_CFG;
			s_r.irq_en   <= `SRAI_RST_IRQ_EN;
			s_r.half_cyc <= `SRAI_RST_HALF_CYC;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign dout    = s_r.dout;
	assign dout_oe = s_r.dout_oe;
	assign irq_out = s_r.irq_out;
	assign irq_oe  = s_r.irq_oe;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_flag_read_cmd;
		cmd_done && !cmd_byte[`SRAI_CMD_WR_BIT] && cmd_sel == `SRAI_A_FLAGS_RCLR;
	endsequence

	sequence s_held_bit;
		s_r.irq_hold && !pins.cs_n && !data_done;
	endsequence

	sequence s_hold_end_pending;
		data_done && s_r.irq_hold && |(s_r.flags & s_r.irq_en);
	endsequence

	a_irq_level: assert property (
		!s_r.irq_hold && |(s_r.flags & s_r.irq_en) |-> s_r.irq_oe)
		else $error("interrupt line not driven while an enabled flag is pending");

	a_irq_release: assert property (
		s_flag_read_cmd |=> s_r.irq_hold && !s_r.irq_oe)
		else $error("interrupt line not released after the flag read command");

	a_irq_held: assert property (
		s_held_bit |=> !s_r.irq_oe)
		else $error("interrupt line driven during the flag data transfer");

	a_irq_relower: assert property (
		s_hold_end_pending |=> !s_r.irq_hold && s_r.irq_oe)
		else $error("pending interrupt not reasserted after the flag transfer");

	a_flags_clear: assert property (
		s_flag_read_cmd |=> s_r.flags == $past(irq_events))
		else $error("flags not cleared by the clear-on-read access");

	a_flags_sticky: assert property (
		|irq_events |=> (s_r.flags & $past(irq_events)) == $past(irq_events))
		else $error("event did not set its flag");

	a_cmd_decode: assert property (
		cmd_done |=> s_r.st == SRAI_DATA && s_r.cmd == $past(cmd_byte)
			&& s_r.nbits == reg_bits($past(cmd_sel)))
		else $error("command byte not decoded");

	a_write_cfg: assert property (
		data_done && s_r.cmd[`SRAI_CMD_WR_BIT] && data_sel == `SRAI_A_ACT_CFG
			|=> {16'h0000, s_r.act_cfg} == ($past(wdata) & 24'h0000ff))
		else $error("configuration write not taken from sampled data");

	a_read_drive: assert property (
		sclk_rise && !pins.cs_n && s_r.st == SRAI_DATA && !s_r.cmd[`SRAI_CMD_WR_BIT]
			|=> s_r.dout_oe && s_r.dout == $past(s_r.dout_sh[23]))
		else $error("read bit not presented on rising serial clock");

	a_rclr_zero: assert property (
		cmd_done && !cmd_byte[`SRAI_CMD_WR_BIT] && cmd_sel == `SRAI_A_ACT_RCLR
			|=> s_r.act_acc == ($past(power.valid) ? $past(act_inc) : 24'h000000))
		else $error("active energy accumulator not cleared on read");

	a_cs_abort: assert property (
		pins.cs_n |=> s_r.st == SRAI_CMD && !s_r.dout_oe && s_r.bitcnt == 5'd0)
		else $error("chip select high did not return to command mode");

	a_done_cmd: assert property (
		data_done ##1 !pins.cs_n [*2] |-> s_r.st == SRAI_CMD)
		else $error("port left command mode after a finished transfer");

	// Periodic latch of the line accumulator after the programmed half-cycle count.
	sequence s_line_wrap;
		half_cycle && s_r.half_cnt + 16'h0001 >= s_r.half_cyc;
	endsequence

	a_line_wrap: assert property (
		s_line_wrap |=> s_r.half_cnt == 16'h0000 && s_r.line_acc == 24'h000000
			&& s_r.line_reg == $past(s_r.line_acc)
			+ ($past(power.valid) ? $past(line_inc) : 24'h000000))
		else $error("line energy not latched at the end of the half-cycle count");

	a_line_step: assert property (
		half_cycle && s_r.half_cnt + 16'h0001 < s_r.half_cyc
			|=> s_r.half_cnt == $past(s_r.half_cnt) + 16'h0001)
		else $error("half-cycle counter did not advance");

	a_write_half: assert property (
		data_done && s_r.cmd[`SRAI_CMD_WR_BIT] && data_sel == `SRAI_A_HALF_CYC
			|=> {8'h00, s_r.half_cyc} == ($past(wdata) & 24'h00ffff))
		else $error("half-cycle count write not taken from sampled data");

	// A read of the read-clear address clears the shared total and is, apart from a 24-bit wrap, the only cycle in which it may drop.
	a_energy_add: assert property (
		power.valid && !(cmd_done && !cmd_byte[`SRAI_CMD_WR_BIT]
			&& cmd_sel == `SRAI_A_ACT_RCLR)
			|=> s_r.act_acc == $past(s_r.act_acc) + $past(act_inc))
		else $error("active energy sample not accumulated");

	a_app_add: assert property (
		power.valid |=> s_r.app_acc == $past(s_r.app_acc) + $past(app_inc))
		else $error("apparent energy sample not accumulated");

	// Flags may only lose bits through the clear-on-read access.
	a_flags_keep: assert property (
		!(cmd_done && !cmd_byte[`SRAI_CMD_WR_BIT] && cmd_sel == `SRAI_A_FLAGS_RCLR)
			|=> (s_r.flags & $past(s_r.flags)) == $past(s_r.flags))
		else $error("event flag lost without a clear-on-read access");

	a_write_word: assert property (
		data_done && s_r.cmd[`SRAI_CMD_WR_BIT] && data_sel == `SRAI_A_IRQ_EN
			|=> {8'h00, s_r.irq_en} == ($past(wdata) & 24'h00ffff))
		else $error("enable mask write not taken from sampled data");

	a_reserved_read: assert property (
		cmd_done && !cmd_byte[`SRAI_CMD_WR_BIT] && cmd_sel == `SRAI_A_RESERVED
			|=> s_r.dout_sh == 24'h000000 && s_r.nbits == `SRAI_W_BYTE)
		else $error("reserved address did not read as one zero byte");

	// Writes to read-only or unmapped addresses still clock all bits but change nothing.
	a_rdonly_write: assert property (
		data_done && s_r.cmd[`SRAI_CMD_WR_BIT] && !(data_sel inside {`SRAI_A_ACT_CFG,
			`SRAI_A_APP_CFG, `SRAI_A_IRQ_EN, `SRAI_A_HALF_CYC})
			|=> $stable(s_r.act_cfg) && $stable(s_r.app_cfg) && $stable(s_r.irq_en)
			&& $stable(s_r.half_cyc))
		else $error("write to a read-only or unmapped address changed a register");

	a_oe_release: assert property (
		data_done |=> !s_r.dout_oe && s_r.st == SRAI_CMD && !s_r.irq_hold)
		else $error("serial output still driven after the last data bit");

	// An aborted flag read must not leave the interrupt line masked.
	a_hold_abort: assert property (
		pins.cs_n |=> !s_r.irq_hold)
		else $error("interrupt hold survived a chip select release");

endmodule
